/* dhx_alu.sv */
/*
 Single-cycle datapath slice for the two signed halving crossed halfword
 operations. One request per cycle, answer registered one edge later.
 Assumes the pipeline holds the condition flags elsewhere and never lets
 this unit touch them; operand values come already read from registers.
*/
`timescale 1ns/1ps
module dhx_alu (
	// Clock and reset
	input  wire logic            clk_sys,
	input  wire logic            resetn,
	// Request from decoder
	input  wire dhx_pkg::dhx_req_s req,
	// Answer to register file
	output dhx_pkg::dhx_rsp_s    rsp
);

	dhx_pkg::dhx_rsp_s next_rsp;
	logic [15:0]       lane_hi;
	logic [15:0]       lane_lo;

	function automatic logic [15:0] half_op(input logic [15:0] a,
		input logic [15:0] b, input logic sub);
		logic signed [16:0] r;
		r = sub ? ($signed({a[15], a}) - $signed({b[15], b}))
			: ($signed({a[15], a}) + $signed({b[15], b}));
		return r[16:1];
	endfunction

	always_comb begin
		next_rsp = '0;
		lane_hi = '0;
		lane_lo = '0;
		case (req.op)
			dhx_pkg::DHX_ADD_SUB_X: begin
				lane_hi = half_op(req.first_op[31:16],
					req.second_op[15:0], 1'b0);
				lane_lo = half_op(req.first_op[15:0],
					req.second_op[31:16], 1'b1);
			end
			dhx_pkg::DHX_SUB_ADD_X: begin
				lane_lo = half_op(req.first_op[31:16],
					req.second_op[15:0], 1'b1);
				lane_hi = half_op(req.first_op[15:0],
					req.second_op[31:16], 1'b0);
			end
			default: begin
				lane_hi = '0;
				lane_lo = '0;
			end
		endcase
		next_rsp.wr_en = req.valid & req.cond_pass;
		next_rsp.wr_reg = req.dst_given ? req.dst_reg
			: req.first_operand_reg;
		next_rsp.wr_data = {lane_hi, lane_lo};
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rsp.wr_en   <= 1'h0;
			rsp.wr_reg  <= dhx_pkg::DHX_REG_RST;
			rsp.wr_data <= dhx_pkg::DHX_DATA_RST;
		end else begin
			rsp <= next_rsp;
		end
	end

	// Assertion helpers, recomputed independently of the function
	logic signed [16:0] chk_hi;
	logic signed [16:0] chk_lo;
	always_comb begin
		if (req.op == dhx_pkg::DHX_ADD_SUB_X) begin
			chk_hi = $signed({req.first_op[31], req.first_op[31:16]})
				+ $signed({req.second_op[15], req.second_op[15:0]});
			chk_lo = $signed({req.first_op[15], req.first_op[15:0]})
				- $signed({req.second_op[31], req.second_op[31:16]});
		end else begin
			chk_hi = $signed({req.first_op[15], req.first_op[15:0]})
				+ $signed({req.second_op[31], req.second_op[31:16]});
			chk_lo = $signed({req.first_op[31], req.first_op[31:16]})
				- $signed({req.second_op[15], req.second_op[15:0]});
		end
	end

	// Lane checks lean on the helper sums, not on half_op
	property p_asx_high;
		@(posedge clk_sys) disable iff (!resetn)
		req.op == dhx_pkg::DHX_ADD_SUB_X
		|=> rsp.wr_data[31:16] == $past(chk_hi[16:1]);
	endproperty
	a_asx_high_lane: assert property (p_asx_high)
		else $error("add-sub high lane wrong");

	property p_asx_low;
		@(posedge clk_sys) disable iff (!resetn)
		req.op == dhx_pkg::DHX_ADD_SUB_X
		|=> rsp.wr_data[15:0] == $past(chk_lo[16:1]);
	endproperty
	a_asx_low_lane: assert property (p_asx_low)
		else $error("add-sub low lane wrong");

	property p_sax_low;
		@(posedge clk_sys) disable iff (!resetn)
		req.op == dhx_pkg::DHX_SUB_ADD_X
		|=> rsp.wr_data[15:0] == $past(chk_lo[16:1]);
	endproperty
	a_sax_low_lane: assert property (p_sax_low)
		else $error("sub-add low lane wrong");

	property p_sax_high;
		@(posedge clk_sys) disable iff (!resetn)
		req.op == dhx_pkg::DHX_SUB_ADD_X
		|=> rsp.wr_data[31:16] == $past(chk_hi[16:1]);
	endproperty
	a_sax_high_lane: assert property (p_sax_high)
		else $error("sub-add high lane wrong");

	// A logical shift would turn negative halves positive
	property p_sign_high;
		@(posedge clk_sys) disable iff (!resetn)
		1'h1 |=> rsp.wr_data[31] == $past(chk_hi[16]);
	endproperty
	a_halve_sign_kept: assert property (p_sign_high)
		else $error("halving lost sign");

	property p_sign_low;
		@(posedge clk_sys) disable iff (!resetn)
		1'h1 |=> rsp.wr_data[15] == $past(chk_lo[16]);
	endproperty
	a_halve_sign_low: assert property (p_sign_low)
		else $error("halving lost low sign");

	property p_cond_fail;
		@(posedge clk_sys) disable iff (!resetn)
		req.valid && !req.cond_pass |=> !rsp.wr_en;
	endproperty
	a_cond_gates_write: assert property (p_cond_fail)
		else $error("write despite failed condition");

	property p_cond_pass;
		@(posedge clk_sys) disable iff (!resetn)
		req.valid && req.cond_pass |=> rsp.wr_en;
	endproperty
	a_write_on_pass: assert property (p_cond_pass)
		else $error("missing write");

	property p_idle;
		@(posedge clk_sys) disable iff (!resetn)
		!req.valid |=> !rsp.wr_en;
	endproperty
	a_idle_no_write: assert property (p_idle)
		else $error("write without request");

	property p_dest_default;
		@(posedge clk_sys) disable iff (!resetn)
		!req.dst_given
		|=> rsp.wr_reg == $past(req.first_operand_reg);
	endproperty
	a_dest_default: assert property (p_dest_default)
		else $error("default destination wrong");

	property p_dest_given;
		@(posedge clk_sys) disable iff (!resetn)
		req.dst_given
		|=> rsp.wr_reg == $past(req.dst_reg);
	endproperty
	a_dest_given: assert property (p_dest_given)
		else $error("given destination wrong");

	// Worst-case operands: a sixteen-bit sum would wrap here
	property p_prec_high;
		@(posedge clk_sys) disable iff (!resetn)
		req.op == dhx_pkg::DHX_ADD_SUB_X
		&& req.first_op[31:16] == 16'h7fff
		&& req.second_op[15:0] == 16'h7fff
		|=> rsp.wr_data[31:16] == 16'h7fff;
	endproperty
	a_lane_precision: assert property (p_prec_high)
		else $error("lane overflowed");

	property p_prec_low;
		@(posedge clk_sys) disable iff (!resetn)
		req.op == dhx_pkg::DHX_SUB_ADD_X
		&& req.first_op[31:16] == 16'h8000
		&& req.second_op[15:0] == 16'h7fff
		|=> rsp.wr_data[15:0] == 16'h8000;
	endproperty
	a_low_precision: assert property (p_prec_low)
		else $error("low lane overflowed");

	c_asx_write: cover property (@(posedge clk_sys) disable iff (!resetn)
		req.valid && req.cond_pass && req.op == dhx_pkg::DHX_ADD_SUB_X);
	c_sax_write: cover property (@(posedge clk_sys) disable iff (!resetn)
		req.valid && req.cond_pass && req.op == dhx_pkg::DHX_SUB_ADD_X);
	c_cond_fail: cover property (@(posedge clk_sys) disable iff (!resetn)
		req.valid && !req.cond_pass);
	c_default_dest: cover property (@(posedge clk_sys) disable iff (!resetn)
		req.valid && !req.dst_given);
	c_write_then_idle: cover property (@(posedge clk_sys) disable iff (!resetn)
		rsp.wr_en && !req.valid);

endmodule

/* dhx_pipe_model.sv */
/*
 Pipeline-side model: presents one decoded request to the unit.
 Assumes the bench calls issue just after a falling clock edge.
*/
`timescale 1ns/1ps
module dhx_pipe_model (
	// Request to unit
	output dhx_pkg::dhx_req_s req
);
	initial req = '0;
	// flag and registers passed as decoded, not checked against SP or PC
	task automatic issue(input dhx_pkg::dhx_req_s r);
		req = r;
	endtask
endmodule

/* dhx_pkg.sv */
/*
 Package for the dual halfword halving crossed add/subtract unit: operation
 encodings, the request and answer carriers, and reset values.
 Assumes the pipeline decoder supplies operands already read from the
 register file.
*/
package dhx_pkg;

	localparam int unsigned DHX_HW = 16;
	localparam int unsigned DHX_RW = 32;
	localparam int unsigned DHX_RA = 4;

	typedef enum logic [0:0] {
		DHX_ADD_SUB_X = 1'h0,
		DHX_SUB_ADD_X = 1'h1
	} dhx_op_e;

	typedef struct packed {
		logic        valid;
		dhx_op_e     op;
		logic        cond_pass;
		logic        dst_given;
		logic [3:0]  dst_reg;
		logic [3:0]  first_operand_reg;
		logic [3:0]  second_operand_reg;
		logic [31:0] first_op;
		logic [31:0] second_op;
	} dhx_req_s;

	typedef struct packed {
		logic        wr_en;
		logic [3:0]  wr_reg;
		logic [31:0] wr_data;
	} dhx_rsp_s;

	localparam logic [31:0] DHX_DATA_RST = 32'h0000_0000;
	localparam logic [3:0]  DHX_REG_RST  = 4'h0;
	localparam logic [3:0]  DHX_REG_SP   = 4'hd;
	localparam logic [3:0]  DHX_REG_PC   = 4'hf;

endpackage

/* dual_halfword_halving_exchange_alu_test.sv */
/*
 Self-checking bench for dhx_alu with hand-written scenarios.
 Assumes the pipeline model drives req and latency is one edge.
*/
`timescale 1ns/1ps
module dual_halfword_halving_exchange_alu_test;
	logic              clk_sys = 1'h0;
	logic              resetn = 1'h0;
	dhx_pkg::dhx_req_s req;
	dhx_pkg::dhx_rsp_s rsp;
	int                mismatches = 0;
	int                n_compared = 0;
	always #2.5 clk_sys = ~clk_sys;
	dhx_pipe_model pipe (.req(req));
	dhx_alu uut (.clk_sys(clk_sys), .resetn(resetn), .req(req), .rsp(rsp));
	function automatic logic [15:0] half(logic [15:0] x, y, logic s);
		logic [16:0] t;
		t = s ? {x[15], x} - {y[15], y} : {x[15], x} + {y[15], y};
		return t[16:1];
	endfunction
	task automatic cmp(logic [36:0] got, logic [36:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h",
				$time, got, exp);
		end
	endtask
	task automatic run(logic op, cp, dg, logic [3:0] rd, rn,
		logic [31:0] a, b);
		dhx_pkg::dhx_req_s r;
		logic [15:0]       hi;
		logic [15:0]       lo;
		r = {1'h1, dhx_pkg::dhx_op_e'(op), cp, dg, rd, rn, 4'h2, a, b};
		hi = op ? half(a[15:0], b[31:16], 1'h0)
			: half(a[31:16], b[15:0], 1'h0);
		lo = op ? half(a[31:16], b[15:0], 1'h1)
			: half(a[15:0], b[31:16], 1'h1);
		@(negedge clk_sys) pipe.issue(r);
		@(negedge clk_sys);
		// Data and register are formed even when the write is refused
		cmp({rsp.wr_en, rsp.wr_reg, rsp.wr_data},
			{cp, dg ? rd : rn, hi, lo});
		// Idle fields are inverted so stale data cannot match
		r = ~r;
		r.valid = 1'h0;
		pipe.issue(r);
		@(negedge clk_sys) cmp(37'(rsp.wr_en), 37'h0);
	endtask
	task automatic t_walk;
		run(1'h0, 1'h1, 1'h1, 4'h3, 4'h1, 32'h00040002, 32'h00060008);
		$display("t_walk done at %0t", $time);
	endtask
	task automatic t_swap;
		run(1'h1, 1'h1, 1'h1, 4'h4, 4'h1, 32'h12348001, 32'hfffe0003);
		$display("t_swap done at %0t", $time);
	endtask
	task automatic t_edge;
		run(1'h0, 1'h1, 1'h1, 4'h5, 4'h1, 32'h7fff8000, 32'h7fff7fff);
		run(1'h1, 1'h1, 1'h1, 4'h6, 4'h1, 32'h80018000, 32'h8000ffff);
		run(1'h1, 1'h1, 1'h1, 4'ha, 4'h1, 32'h80000000, 32'h00007fff);
		$display("t_edge done at %0t", $time);
	endtask
	task automatic t_cond;
		run(1'h0, 1'h0, 1'h1, 4'h7, 4'h1, 32'h00100010, 32'h00200020);
		$display("t_cond done at %0t", $time);
	endtask
	task automatic t_omit;
		run(1'h1, 1'h1, 1'h0, 4'h9, 4'hc, 32'h00400008, 32'h00020006);
		$display("t_omit done at %0t", $time);
	endtask
	task automatic t_reset;
		dhx_pkg::dhx_req_s r;
		r = {1'h1, dhx_pkg::DHX_ADD_SUB_X, 1'h1, 1'h1, 4'h8, 4'h1, 4'h2,
			32'h00020004, 32'h00060002};
		@(negedge clk_sys) pipe.issue(r);
		@(negedge clk_sys) resetn = 1'h0;
		#1 cmp({rsp.wr_en, rsp.wr_reg, rsp.wr_data},
			{1'h0, dhx_pkg::DHX_REG_RST, dhx_pkg::DHX_DATA_RST});
		r.valid = 1'h0;
		pipe.issue(r);
		@(negedge clk_sys) resetn = 1'h1;
		@(negedge clk_sys) cmp(37'(rsp.wr_en), 37'h0);
		$display("t_reset done at %0t", $time);
	endtask
	task automatic conclude;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		#20000;
		mismatches++;
		conclude;
	end
	initial begin
		repeat (12) @(posedge clk_sys);
		@(negedge clk_sys) resetn = 1'h1;
		t_walk;
		t_swap;
		t_edge;
		t_cond;
		t_omit;
		t_reset;
		conclude;
	end
endmodule
